/* File: rtl/sysref_clock_pkg.sv */
/*
  Constants for the reference-timing and clock configuration register group:
  register offsets, field positions, reset values and the delay step size.
  Assumes nothing of its surroundings; referenced by name from the register group file, not from the edge detector.
*/
package sysref_clock_pkg;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [11:0] CLOCK_CONTROL0_OFS       = 12'h030; // Clear controls
  localparam logic [11:0] CLOCK_STATUS_OFS         = 12'h031; // Edge status
  localparam logic [11:0] SYSREF_DELAY_CONTROL_OFS = 12'h032;
  localparam logic [11:0] ANALOG_MISC_CONTROL_OFS  = 12'h033;
  localparam logic [11:0] INPUT_CLAMP_CONTROL_OFS  = 12'h034;
  localparam logic [11:0] LANE_DRIVER_CONFIG_OFS   = 12'h040;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] CLOCK_CONTROL0_RST       = 8'hC0;
  localparam logic [7:0] SYSREF_DELAY_CONTROL_RST = 8'h80;
  localparam logic [7:0] ANALOG_MISC_CONTROL_RST  = 8'hC3;
  localparam logic [7:0] INPUT_CLAMP_CONTROL_RST  = 8'h2F;
  localparam logic [7:0] LANE_DRIVER_CONFIG_RST   = 8'h04;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int EDGE_SEEN_BIT        = 7; // Status: reference edge seen
  localparam int MARGINAL_BIT         = 6; // Status: marginal capture
  localparam int EDGE_SEEN_CLEAR_BIT  = 5; // Control 0: seen-flag clear
  localparam int MARGINAL_CLEAR_BIT   = 4; // Control 0: marginal-flag clear
  localparam int SYNC_POWERDOWN_BIT   = 2; // Analog misc
  localparam int CLAMP_ENABLE_BIT     = 5; // Input clamp
  localparam int DELAY_MSB            = 3; // Delay steps field 3..0
  localparam int PREEMPHASIS_MSB      = 3; // Pre-emphasis field 3..0

  // Fixed pattern in the low six status bits
  localparam logic [5:0] STATUS_RESERVED_PATTERN = 6'h07;

  // Nominal delay added per step of the reference delay field, in ps
  localparam int REF_DELAY_STEP_PS = 20;

endpackage

/* File: rtl/reference_edge_detector.sv */
/*
  Reference edge detector: watches two samples of the delayed reference taken
  just before and just after the device clock edge by the analog delay line.
  Assumes both samples are already synchronous to clk.
*/
module reference_edge_detector (
  input  wire logic clk,            // Device clock
  input  wire logic resetn,         // Asynchronous reset, active low
  input  wire logic ce,             // Clock enable, freezes state when low
  input  wire logic sample_early,   // Reference sampled ahead of the edge
  input  wire logic sample_late,    // Reference sampled at the edge
  output logic      edge_pulse,     // One-cycle pulse on a rising edge
  output logic      marginal_pulse  // One-cycle pulse on a marginal edge
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic prev_reg,     prev_next;     // Last official sample
  logic edge_reg,     edge_next;     // Registered edge pulse
  logic marginal_reg, marginal_next; // Registered marginal pulse

  // Next values: the late sample is the official capture; everything holds
  // while the clock enable is low, so a pending pulse is never lost
  always_comb begin
    prev_next     = prev_reg;
    edge_next     = edge_reg;
    marginal_next = marginal_reg;
    if (ce) begin
      prev_next     = sample_late;
      // Rising edge on the captured reference
      edge_next     = sample_late & ~prev_reg;
      // Samples disagree around the edge, so setup or hold is in doubt;
      // a fast sweep can still slip through between samples
      marginal_next = (sample_early ^ sample_late) & ~prev_reg;
    end
  end

  // Registers only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_reg     <= 1'b0;
      edge_reg     <= 1'b0;
      marginal_reg <= 1'b0;
    end else begin
      prev_reg     <= prev_next;
      edge_reg     <= edge_next;
      marginal_reg <= marginal_next;
    end
  end

  assign edge_pulse     = edge_reg;
  assign marginal_pulse = marginal_reg;

endmodule

/* File: rtl/sysref_clock_status_config.sv */
/*
  Reference-timing and clock configuration register group: status flags for
  reference edges, reference delay, sync receiver power-down, input clamp
  and lane pre-emphasis. Assumes a decoded register port synchronous to clk
  and reference samples delivered by the analog delay line.
*/
// Behaviour
// - Bit 7 flags a reference edge, sticky
// - Seen flag clears on clear bit one-then-zero
// - Bit 6 flags a marginally captured edge
// - Marginal flag clears on its one-then-zero
// - Low six status bits read 000111
// - Four-bit delay field, 20 ps steps, default 0
// - Bit 2 powers down sync receiver, reset 0
// - Sync receiver also feeds the time marker
// - Bit 5 enables input clamp, reset one
// - Bits 3..0 set pre-emphasis, reset 4
module sysref_clock_status_config #(
  parameter int ADDR_W = 12  // Register address width
) (
  input  wire logic              clk,                     // Device clock, 40 MHz
  input  wire logic              resetn,                  // Async reset, active low
  input  wire logic              ce,                      // Clock enable
  input  wire logic              reg_wr,                  // Register write strobe
  input  wire logic              reg_rd,                  // Register read strobe
  input  wire logic [ADDR_W-1:0] reg_addr,                // Register address
  input  wire logic [7:0]        reg_wdata,               // Write data
  output logic      [7:0]        reg_rdata,               // Read data, one cycle late
  input  wire logic              sysref_sample_early,     // Delayed reference, early
  input  wire logic              sysref_sample_late,      // Delayed reference, at edge
  input  wire logic              sync_receiver_in,        // Differential sync receiver
  output logic      [3:0]        reference_delay_steps,   // To analog delay line
  output logic                   sync_receiver_powerdown, // Receiver power-down
  output logic                   sync_out,                // Receiver level to link
  output logic                   time_marker_input,       // Receiver level to stamp
  output logic                   input_clamp_enable,      // Analog clamp enable
  output logic      [3:0]        preemphasis_strength     // Lane driver strength
);

  // ==========================================================================
  // Elaboration check
  // ==========================================================================
  generate
    if (ADDR_W < 7 || ADDR_W > 12) begin : g_bad_addr
      $error("ADDR_W must lie between 7 and 12");
    end
  endgenerate

  // Address compare against a 12-bit package offset
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    hit = (12'(a) == ofs);
  endfunction

  // ==========================================================================
  // Edge detection
  // ==========================================================================
  logic edge_pulse;     // Rising edge on delayed reference
  logic marginal_pulse; // Edge captured with doubtful timing

  reference_edge_detector u_edge (
    .clk            (clk),
    .resetn         (resetn),
    .ce             (ce),
    .sample_early   (sysref_sample_early),
    .sample_late    (sysref_sample_late),
    .edge_pulse     (edge_pulse),
    .marginal_pulse (marginal_pulse)
  );

  // ==========================================================================
  // Register state
  // ==========================================================================
  logic [7:0] clock_control0_reg,       clock_control0_next;
  logic [7:0] sysref_delay_control_reg, sysref_delay_control_next;
  logic [7:0] analog_misc_control_reg,  analog_misc_control_next;
  logic [7:0] input_clamp_control_reg,  input_clamp_control_next;
  logic [7:0] lane_driver_config_reg,   lane_driver_config_next;
  logic       edge_seen_reg,            edge_seen_next;   // Sticky seen flag
  logic       marginal_reg,             marginal_next;    // Sticky marginal flag
  logic [7:0] rdata_reg,                rdata_next;       // Read data
  logic       sync_reg,                 sync_next;        // Receiver level
  logic [7:0] status_value;                               // Assembled status

  // Status word: two flags over the fixed pattern
  assign status_value = {edge_seen_reg, marginal_reg, sysref_clock_pkg::STATUS_RESERVED_PATTERN};

  // Next values for registers, flags and read data
  always_comb begin
    logic seen_clear;     // Falling edge written onto seen-clear bit
    logic marginal_clear; // Falling edge written onto marginal-clear bit
    seen_clear                = 1'b0;
    marginal_clear            = 1'b0;
    clock_control0_next       = clock_control0_reg;
    sysref_delay_control_next = sysref_delay_control_reg;
    analog_misc_control_next  = analog_misc_control_reg;
    input_clamp_control_next  = input_clamp_control_reg;
    lane_driver_config_next   = lane_driver_config_reg;
    edge_seen_next            = edge_seen_reg;
    marginal_next             = marginal_reg;
    rdata_next                = rdata_reg;
    sync_next                 = sync_reg;
    if (ce) begin
      // Writes; unmapped and status addresses ignore them
      if (reg_wr) begin
        if (hit(reg_addr, sysref_clock_pkg::CLOCK_CONTROL0_OFS)) begin
          clock_control0_next = reg_wdata;
          // Clear only on one followed by zero
          seen_clear = clock_control0_reg[sysref_clock_pkg::EDGE_SEEN_CLEAR_BIT]
                     & ~reg_wdata[sysref_clock_pkg::EDGE_SEEN_CLEAR_BIT];
          // Same sequence on its own bit
          marginal_clear = clock_control0_reg[sysref_clock_pkg::MARGINAL_CLEAR_BIT]
                         & ~reg_wdata[sysref_clock_pkg::MARGINAL_CLEAR_BIT];
        end
        if (hit(reg_addr, sysref_clock_pkg::SYSREF_DELAY_CONTROL_OFS)) begin
          sysref_delay_control_next = reg_wdata;
        end
        if (hit(reg_addr, sysref_clock_pkg::ANALOG_MISC_CONTROL_OFS)) begin
          analog_misc_control_next = reg_wdata;
        end
        if (hit(reg_addr, sysref_clock_pkg::INPUT_CLAMP_CONTROL_OFS)) begin
          input_clamp_control_next = reg_wdata;
        end
        if (hit(reg_addr, sysref_clock_pkg::LANE_DRIVER_CONFIG_OFS)) begin
          lane_driver_config_next = reg_wdata;
        end
      end
      // Sticky flags: a new event wins over a clear in the same cycle
      edge_seen_next = edge_pulse | (edge_seen_reg & ~seen_clear);
      marginal_next  = marginal_pulse | (marginal_reg & ~marginal_clear);
      // Reads; unmapped addresses answer zero
      if (reg_rd) begin
        if (hit(reg_addr, sysref_clock_pkg::CLOCK_CONTROL0_OFS)) begin
          rdata_next = clock_control0_reg;
        end else if (hit(reg_addr, sysref_clock_pkg::CLOCK_STATUS_OFS)) begin
          rdata_next = status_value;
        end else if (hit(reg_addr, sysref_clock_pkg::SYSREF_DELAY_CONTROL_OFS)) begin
          rdata_next = sysref_delay_control_reg;
        end else if (hit(reg_addr, sysref_clock_pkg::ANALOG_MISC_CONTROL_OFS)) begin
          rdata_next = analog_misc_control_reg;
        end else if (hit(reg_addr, sysref_clock_pkg::INPUT_CLAMP_CONTROL_OFS)) begin
          rdata_next = input_clamp_control_reg;
        end else if (hit(reg_addr, sysref_clock_pkg::LANE_DRIVER_CONFIG_OFS)) begin
          rdata_next = lane_driver_config_reg;
        end else begin
          rdata_next = 8'h00;
        end
      end
      // One receiver serves both sync and time marker; silent when off
      sync_next = sync_receiver_in
                & ~analog_misc_control_reg[sysref_clock_pkg::SYNC_POWERDOWN_BIT];
    end
  end

  // Registers only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clock_control0_reg       <= sysref_clock_pkg::CLOCK_CONTROL0_RST;
      sysref_delay_control_reg <= sysref_clock_pkg::SYSREF_DELAY_CONTROL_RST;
      analog_misc_control_reg  <= sysref_clock_pkg::ANALOG_MISC_CONTROL_RST;
      input_clamp_control_reg  <= sysref_clock_pkg::INPUT_CLAMP_CONTROL_RST;
      lane_driver_config_reg   <= sysref_clock_pkg::LANE_DRIVER_CONFIG_RST;
      edge_seen_reg            <= 1'b0;
      marginal_reg             <= 1'b0;
      rdata_reg                <= 8'h00;
      sync_reg                 <= 1'b0;
    end else begin
      clock_control0_reg       <= clock_control0_next;
      sysref_delay_control_reg <= sysref_delay_control_next;
      analog_misc_control_reg  <= analog_misc_control_next;
      input_clamp_control_reg  <= input_clamp_control_next;
      lane_driver_config_reg   <= lane_driver_config_next;
      edge_seen_reg            <= edge_seen_next;
      marginal_reg             <= marginal_next;
      rdata_reg                <= rdata_next;
      sync_reg                 <= sync_next;
    end
  end

  // ==========================================================================
  // Outputs, each straight from a flip-flop
  // ==========================================================================
  assign reg_rdata               = rdata_reg;
  assign reference_delay_steps   =
    sysref_delay_control_reg[sysref_clock_pkg::DELAY_MSB:0];
  assign sync_receiver_powerdown =
    analog_misc_control_reg[sysref_clock_pkg::SYNC_POWERDOWN_BIT];
  assign sync_out                = sync_reg;
  assign time_marker_input       = sync_reg;
  assign input_clamp_enable      =
    input_clamp_control_reg[sysref_clock_pkg::CLAMP_ENABLE_BIT];
  assign preemphasis_strength    =
    lane_driver_config_reg[sysref_clock_pkg::PREEMPHASIS_MSB:0];

  // ==========================================================================
  // Assertions
  // ==========================================================================
  logic wr_ctl0; // Write to control 0 this cycle
  assign wr_ctl0 = ce & reg_wr & hit(reg_addr, sysref_clock_pkg::CLOCK_CONTROL0_OFS);

  // Second step of the clear: a zero written over a stored one, with no
  // new edge in the same cycle (a new edge would win)
  sequence s_seen_drop;
    wr_ctl0 && clock_control0_reg[sysref_clock_pkg::EDGE_SEEN_CLEAR_BIT]
    && !reg_wdata[sysref_clock_pkg::EDGE_SEEN_CLEAR_BIT] && !edge_pulse;
  endsequence

  property p_seen_set;
    @(posedge clk) disable iff (!resetn) (ce && edge_pulse) |=> edge_seen_reg;
  endproperty
  a_seen_set: assert property (p_seen_set) else $error("seen flag missed an edge");

  property p_seen_clear;
    @(posedge clk) disable iff (!resetn)
      s_seen_drop |=> !edge_seen_reg;
  endproperty
  a_seen_clear: assert property (p_seen_clear) else $error("seen flag not cleared");

  property p_seen_hold;
    @(posedge clk) disable iff (!resetn)
      (edge_seen_reg && !wr_ctl0) |=> edge_seen_reg;
  endproperty
  a_seen_hold: assert property (p_seen_hold) else $error("seen flag dropped alone");

  property p_marginal_set;
    @(posedge clk) disable iff (!resetn)
      (ce && sysref_sample_early != sysref_sample_late && !u_edge.prev_reg) |=> ##1 marginal_reg;
  endproperty
  a_marginal_set: assert property (p_marginal_set) else $error("marginal flag missed");

  property p_marginal_clear;
    @(posedge clk) disable iff (!resetn)
      (wr_ctl0 && clock_control0_reg[sysref_clock_pkg::MARGINAL_CLEAR_BIT]
       && !reg_wdata[sysref_clock_pkg::MARGINAL_CLEAR_BIT] && !marginal_pulse) |=> !marginal_reg;
  endproperty
  a_marginal_clear: assert property (p_marginal_clear) else $error("marginal kept");

  property p_status_pattern;
    @(posedge clk) disable iff (!resetn)
      (ce && reg_rd && hit(reg_addr, sysref_clock_pkg::CLOCK_STATUS_OFS))
      |=> reg_rdata == {$past(edge_seen_reg), $past(marginal_reg), 6'h07};
  endproperty
  a_status_pattern: assert property (p_status_pattern) else $error("bad status read");

  property p_delay_write;
    @(posedge clk) disable iff (!resetn)
      (ce && reg_wr && hit(reg_addr, sysref_clock_pkg::SYSREF_DELAY_CONTROL_OFS))
      |=> reference_delay_steps == $past(reg_wdata[3:0]);
  endproperty
  a_delay_write: assert property (p_delay_write) else $error("delay not applied");

  property p_receiver_off;
    @(posedge clk) disable iff (!resetn)
      (ce && sync_receiver_powerdown) |=> (!sync_out && !time_marker_input);
  endproperty
  a_receiver_off: assert property (p_receiver_off) else $error("receiver not silent");

  property p_shared_receiver;
    @(posedge clk) disable iff (!resetn) sync_out == time_marker_input;
  endproperty
  a_shared_receiver: assert property (p_shared_receiver) else $error("outputs differ");

  property p_clamp_write;
    @(posedge clk) disable iff (!resetn)
      (ce && reg_wr && hit(reg_addr, sysref_clock_pkg::INPUT_CLAMP_CONTROL_OFS))
      |=> input_clamp_enable == $past(reg_wdata[5]);
  endproperty
  a_clamp_write: assert property (p_clamp_write) else $error("clamp not applied");

  property p_preemph_write;
    @(posedge clk) disable iff (!resetn)
      (ce && reg_wr && hit(reg_addr, sysref_clock_pkg::LANE_DRIVER_CONFIG_OFS))
      |=> preemphasis_strength == $past(reg_wdata[3:0]);
  endproperty
  a_preemph_write: assert property (p_preemph_write) else $error("pre-emphasis wrong");

endmodule

/* File: tb/reference_source_model.sv */
/*
  Far-side model: the reference source that feeds the delayed reference
  samples and the differential sync receiver line of the register group.
  Assumes the bench raises fire to launch one reference pulse.
*/
module reference_source_model (
  input  wire logic clk,          // Device clock
  input  wire logic fire,         // Rising level launches one reference pulse
  input  wire logic marginal,     // Pulse lands on the clock edge when high
  input  wire logic sync_drive,   // Level wanted on the sync receiver
  output logic      sample_early, // Reference sampled ahead of the edge
  output logic      sample_late,  // Reference sampled at the edge
  output logic      sync_level    // Receiver output toward the device
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Reference pulse
  // ==========================================================================
  initial begin
    sample_early = 1'b0;
    sample_late  = 1'b0;
  end

  // A marginal edge shows as early and late samples that disagree; the pulse
  // then lasts four cycles so one rising edge is seen, never two
  always @(posedge fire) begin
    @(negedge clk);
    sample_late  <= 1'b1;
    sample_early <= !marginal;
    @(negedge clk);
    sample_early <= 1'b1;
    repeat (3) @(negedge clk);
    sample_early <= 1'b0;
    sample_late  <= 1'b0;
  end

  // Receiver line passes straight through; power-down is applied inside the device
  assign sync_level = sync_drive;
endmodule

/* File: tb/sysref_clock_status_config_test.sv */
/*
  Self-checking bench for the reference-timing register group: reset
  values, random writes, sticky flags with their clears, sync receiver path
  and clock enable. Assumes the far side comes from reference_source_model.
*/
module sysref_clock_status_config_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        clk       = 1'b0;  // 40 MHz device clock
  logic        resetn    = 1'b0;  // Held low for two cycles
  logic        ce        = 1'b1;  // Clock enable
  logic        reg_wr    = 1'b0;  // Write strobe
  logic        reg_rd    = 1'b0;  // Read strobe
  logic [11:0] reg_addr  = 12'h000;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic        fire      = 1'b0;  // Launch request to the source model
  logic        marginal  = 1'b0;
  logic        sync_drive = 1'b0;
  logic        s_early, s_late, s_sync;
  logic [3:0]  delay_steps, preemph;
  logic        pd, sync_out, marker, clamp;
  logic [7:0]  mdl [int];         // Reference model of RW registers
  logic        seen, marg, last_sync;
  int          err_total, checked;
  int          seed = 32'hD9AA33F0;
  logic [11:0] ofs [5] = '{12'h032, 12'h033, 12'h034, 12'h040, 12'h030};

  always #12.5 clk = ~clk;

  sysref_clock_status_config dut (
    .clk(clk), .resetn(resetn), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sysref_sample_early(s_early), .sysref_sample_late(s_late),
    .sync_receiver_in(s_sync), .reference_delay_steps(delay_steps),
    .sync_receiver_powerdown(pd), .sync_out(sync_out),
    .time_marker_input(marker), .input_clamp_enable(clamp),
    .preemphasis_strength(preemph));

  reference_source_model src (
    .clk(clk), .fire(fire), .marginal(marginal), .sync_drive(sync_drive),
    .sample_early(s_early), .sample_late(s_late), .sync_level(s_sync));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Model back to the reset state of registers and flags
  task automatic mdl_reset();
    mdl[12'h030] = 8'hC0;
    mdl[12'h032] = 8'h80;
    mdl[12'h033] = 8'hC3;
    mdl[12'h034] = 8'h2F;
    mdl[12'h040] = 8'h04;
    seen = 1'b0;
    marg = 1'b0;
  endtask

  // Expected read value; unmapped places read zero
  function automatic logic [7:0] exp_of(input logic [11:0] a);
    if (a == 12'h031) return {seen, marg, 6'h07};
    if (mdl.exists(a)) return mdl[a];
    return 8'h00;
  endfunction

  // Entered at a falling edge; the idle cycle after keeps strobes apart
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    if (a == 12'h030 && mdl[a][5] && !d[5]) seen = 1'b0;
    if (a == 12'h030 && mdl[a][4] && !d[4]) marg = 1'b0;
    if (mdl.exists(a)) mdl[a] = d;
    @(negedge clk);
  endtask

  task automatic rd(input logic [11:0] a);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    cmp($sformatf("read %h", a), exp_of(a), reg_rdata);
    @(negedge clk);
  endtask

  task automatic outs();
    cmp("delay", {4'h0, mdl[12'h032][3:0]}, {4'h0, delay_steps});
    cmp("powerdown", {7'h00, mdl[12'h033][2]}, {7'h00, pd});
    cmp("clamp", {7'h00, mdl[12'h034][5]}, {7'h00, clamp});
    cmp("preemph", {4'h0, mdl[12'h040][3:0]}, {4'h0, preemph});
  endtask

  // One reference pulse; the flags are due two edges after the capture
  task automatic ref_edge(input logic m);
    marginal = m;
    fire = 1'b1;
    repeat (7) @(negedge clk);
    fire = 1'b0;
    seen = 1'b1;
    if (m) marg = 1'b1;
  endtask

  task automatic close_out();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog: the sequence needs well under a thousand cycles
  // ==========================================================================
  initial begin
    #100000;
    err_total++;
    close_out();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    mdl_reset();
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    // Reset values, status pattern and an unmapped place
    outs();
    foreach (ofs[i]) rd(ofs[i]);
    rd(12'h031);
    rd(12'h035);
    // Random contents; clear bits kept low so no flag is touched yet
    for (int k = 0; k < 3; k++) begin
      foreach (ofs[i]) wr(ofs[i], 8'($random(seed)) & 8'hCF);
      foreach (ofs[i]) rd(ofs[i]);
      outs();
    end
    wr(12'h031, 8'hFF);
    wr(12'h035, 8'h5A);
    rd(12'h031);
    rd(12'h035);
    // Sticky flags and their one-then-zero clears
    ref_edge(1'b0);
    rd(12'h031);
    ref_edge(1'b1);
    rd(12'h031);
    wr(12'h030, 8'h00);
    rd(12'h031);
    wr(12'h030, 8'h20);
    rd(12'h031);
    wr(12'h030, 8'h00);
    rd(12'h031);
    wr(12'h030, 8'h10);
    wr(12'h030, 8'h00);
    rd(12'h031);
    // Shared receiver, powered then powered down
    for (int p = 0; p < 2; p++) begin
      wr(12'h033, p ? 8'hC7 : 8'hC3);
      for (int k = 0; k < 8; k++) begin
        sync_drive = 1'($random(seed));
        last_sync = sync_drive & !mdl[12'h033][2];
        @(negedge clk);
        cmp("sync", {7'h00, last_sync}, {7'h00, sync_out});
        cmp("marker", {7'h00, last_sync}, {7'h00, marker});
      end
    end
    wr(12'h033, 8'hC3);
    // Reset in mid-run with both flags set drops flags and registers
    ref_edge(1'b1);
    resetn = 1'b0;
    @(negedge clk);
    resetn = 1'b1;
    mdl_reset();
    outs();
    rd(12'h031);
    foreach (ofs[j]) rd(ofs[j]);
    // A write with the clock enable low is not taken
    ce = 1'b0;
    reg_wr = 1'b1;
    reg_addr = 12'h040;
    reg_wdata = 8'h0A;
    @(negedge clk);
    reg_wr = 1'b0;
    ce = 1'b1;
    @(negedge clk);
    rd(12'h040);
    outs();
    close_out();
  end
endmodule
